// >>> design/tc_mark_pipe.sv
// One output lane: converter word and mark bit in one pipeline.
// Assumes the caller registers its mark source in step with the word.
`timescale 1ns/1ps
module tc_mark_pipe import tc_pkg::*; #(
  parameter int LAT = 4
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire tc_sample_t conv,
  input  wire logic       mark,
  input  wire logic       ins_en,
  output tc_sample_t      out_reg
);
  tc_sample_t stage_reg [LAT];

  // Word and mark share stage zero so both see one latency.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < LAT; i++) stage_reg[i] <= 12'h000;
    end else begin
      stage_reg[0] <= ins_en ? {conv[11:1], mark} : conv; // see [R1]
      for (int i = 1; i < LAT; i++) stage_reg[i] <= stage_reg[i-1];
    end
  end

  // The last stage feeds the lane pins.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) out_reg <= 12'h000;
    else out_reg <= stage_reg[LAT-1]; // see [R2]
  end

  property p_mark_lsb;
    @(posedge clk) disable iff (!rstn)
    ##(LAT+1) $past(ins_en, LAT+1) |-> out_reg[0] == $past(mark, LAT+1);
  endproperty
  a_mark_lsb: assert property (p_mark_lsb) // see [R1]
    else $error("mark bit not in sample lsb");

  property p_upper_bits;
    @(posedge clk) disable iff (!rstn)
    ##(LAT+1) 1'b1 |-> out_reg[11:1] == $past(conv[11:1], LAT+1);
  endproperty
  a_upper_bits: assert property (p_upper_bits) // see [R2]
    else $error("upper sample bits latency mismatch");
endmodule

// >>> design/tc_ramp.sv
// Coarse delay engine: direct load or gradual ramp to the target.
// Assumes one write pulse per register write.
`timescale 1ns/1ps
`include "tc_defs.svh"
module tc_ramp import tc_pkg::*; (
  input  wire logic clk,
  input  wire logic rstn,
  tc_ramp_if.eng    rif
);
  logic [8:0] tick_reg;
  logic       step;

  // Slow steps once per 256 cycles, fast four times per 256.
  assign step = (tick_reg == 9'h000);

  // Tick counter restarts on each write so a new ramp starts clean.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) tick_reg <= `TC_RAMP_SLOW_CYC - 9'h001;
    else if (rif.wr || step)
      tick_reg <= (rif.fast ? `TC_RAMP_FAST_CYC : `TC_RAMP_SLOW_CYC)
                  - 9'h001; // see [R14]
    else tick_reg <= tick_reg - 9'h001;
  end

  // Current coarse setting walks one step toward the target.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rif.cur  <= `TC_RST_COARSE;
      rif.busy <= 1'b0;
    end else if (rif.wr && !rif.ramp_en) begin
      rif.cur  <= rif.target; // see [R16]
      rif.busy <= 1'b0;
    end else if (rif.wr) begin
      rif.busy <= (rif.target != rif.cur); // see [R15]
    end else if (rif.busy && step) begin
      rif.cur  <= (rif.cur < rif.target) ? rif.cur + 8'h01
                                         : rif.cur - 8'h01; // see [R14]
      rif.busy <= ((rif.cur < rif.target ? rif.cur + 8'h01
                   : rif.cur - 8'h01) != rif.target); // see [R16]
    end
  end

  property p_direct;
    @(posedge clk) disable iff (!rstn)
    rif.wr && !rif.ramp_en |=> rif.cur == $past(rif.target) && !rif.busy;
  endproperty
  a_direct: assert property (p_direct) // see [R16]
    else $error("direct coarse load failed");

  property p_ramp_start;
    @(posedge clk) disable iff (!rstn)
    rif.wr && rif.ramp_en && rif.target != rif.cur
      |=> rif.busy && $stable(rif.cur);
  endproperty
  a_ramp_start: assert property (p_ramp_start) // see [R15]
    else $error("ramp did not start");

  property p_ramp_hold;
    @(posedge clk) disable iff (!rstn)
    rif.busy && !rif.wr && !step |=> $stable(rif.cur);
  endproperty
  a_ramp_hold: assert property (p_ramp_hold) // see [R14]
    else $error("coarse moved between steps");
endmodule

// >>> design/tc_timing_ctrl.sv
// Sample clock timing control: mark insertion, sample mode,
// sampling delay controls, coarse ramp and SYSREF divider reset.
// Assumes all inputs synchronous to clk and a one-cycle register port.
//
// Functional notes
// [R1] Mark enable replaces every sample lsb with the sampled mark.
// [R2] Upper eleven bits and mark bit travel with identical latency.
// [R3] Trigger may be asynchronous; sampled alongside the analog input.
// [R4] Mark source select takes the mark from SYSREF instead.
// [R5] Dual mode samples rising edge; single mode both edges.
// [R6] Device clock alone times sampling, logic and lane outputs.
// [R7] Captured SYSREF resets clock dividers and strobe generator.
// [R8] Periodic SYSREF rate is clock over (demux+1) x frame x n.
// [R9] SYSREF must be caught on a deterministic clock edge.
// [R10] Invert control delays sampling by half a clock period.
// [R11] Coarse and fine each have 256 settings; all delays add.
// [R12] Programmed delay shifts every internal clock and SYSREF capture.
// [R13] Lane receiver must tolerate timing shifts from delay changes.
// [R14] Ramp moves one step per 256 cycles slow, four fast.
// [R15] With ramp enabled every coarse write starts a new ramp.
// [R16] Without ramp coarse loads directly; ramp ends at target.
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "tc_defs.svh"
module tc_timing_ctrl import tc_pkg::*; #(
  parameter int PIPE_LAT = 4
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  input  wire tc_sample_t  conv_a,
  input  wire tc_sample_t  conv_b,
  input  wire logic [1:0]  trigger_mark_input,
  input  wire logic        sysref_in,
  output tc_sample_t       lane_a_data,
  output tc_sample_t       lane_b_data,
  output logic             lane_clock,
  output logic             lane_strobe,
  output logic             delay_invert,
  output tc_delay_t        delay_coarse,
  output tc_delay_t        delay_fine,
  output logic             single_channel
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic       sysref_as_mark_select_reg;
  logic       mark_insert_enable_reg;
  logic       clock_invert_delay_reg;
  logic       delay_ramp_rate_reg;
  logic       delay_ramp_enable_reg;
  tc_delay_t  coarse_delay_step_reg;
  tc_delay_t  fine_delay_step_reg;
  tc_mode_e   mode_reg;
  logic [1:0] demux_factor_setting_reg;
  logic [7:0] frame_length_setting_reg;
  logic       sysref_seen_reg;

  // ----------------------------------------------------------------
  // Internal signals
  // ----------------------------------------------------------------
  logic        wr_clk_ctrl;
  logic        wr_mark;
  logic        wr_delay;
  logic        wr_coarse;
  logic        wr_fine;
  logic        wr_mode;
  logic        wr_demux;
  logic        wr_frame;
  logic        wr_status;
  logic        sysref_reg;
  logic        sysref_prev_reg;
  logic        sysref_edge;
  logic [10:0] frame_period;
  logic [10:0] frame_cnt_reg;
  logic [10:0] frame_cnt_next;
  logic        frame_last;
  logic        mark_a_reg;
  logic        mark_b_reg;
  tc_sample_t  conv_a_reg;
  tc_sample_t  conv_b_reg;
  logic        mark_a_next;
  logic        mark_b_next;
  logic [15:0] rdata_next;

  tc_ramp_if rif ();

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // One strobe per register; unmapped writes are dropped.
  assign wr_clk_ctrl = reg_wr && (reg_addr == `TC_ADDR_CLK_CTRL_ONE);
  assign wr_mark     = reg_wr && (reg_addr == `TC_ADDR_MARK_CTRL);
  assign wr_delay    = reg_wr && (reg_addr == `TC_ADDR_DELAY_CTRL);
  assign wr_coarse   = reg_wr && (reg_addr == `TC_ADDR_COARSE);
  assign wr_fine     = reg_wr && (reg_addr == `TC_ADDR_FINE);
  assign wr_mode     = reg_wr && (reg_addr == `TC_ADDR_MODE);
  assign wr_demux    = reg_wr && (reg_addr == `TC_ADDR_DEMUX);
  assign wr_frame    = reg_wr && (reg_addr == `TC_ADDR_FRAME);
  assign wr_status   = reg_wr && (reg_addr == `TC_ADDR_STATUS);

  // ----------------------------------------------------------------
  // Mark source controls
  // ----------------------------------------------------------------
  // Selects SYSREF or the trigger pins as mark source.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) sysref_as_mark_select_reg <= 1'b0;
    else if (wr_clk_ctrl)
      sysref_as_mark_select_reg <= reg_wdata[`TC_BIT_SYSREF_MARK];
  end

  // Enables replacing the sample lsb with the mark.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) mark_insert_enable_reg <= 1'b0;
    else if (wr_mark)
      mark_insert_enable_reg <= reg_wdata[`TC_BIT_MARK_EN];
  end

  // ----------------------------------------------------------------
  // Sampling delay controls
  // ----------------------------------------------------------------
  // Half-period invert and ramp options share one register.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clock_invert_delay_reg <= 1'b0;
      delay_ramp_rate_reg    <= 1'b0;
      delay_ramp_enable_reg  <= 1'b0;
    end else if (wr_delay) begin
      clock_invert_delay_reg <= reg_wdata[`TC_BIT_INV]; // see [R10]
      delay_ramp_rate_reg    <= reg_wdata[`TC_BIT_RAMP_FAST];
      delay_ramp_enable_reg  <= reg_wdata[`TC_BIT_RAMP_EN];
    end
  end

  // Coarse target and fine setting, 256 codes each.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      coarse_delay_step_reg <= `TC_RST_COARSE;
      fine_delay_step_reg   <= `TC_RST_FINE;
    end else begin
      if (wr_coarse) coarse_delay_step_reg <= reg_wdata[7:0]; // see [R11]
      if (wr_fine)   fine_delay_step_reg   <= reg_wdata[7:0]; // see [R11]
    end
  end

  // The ramp engine sees the raw write so each write restarts it.
  assign rif.wr      = wr_coarse; // see [R15]
  assign rif.target  = reg_wdata[7:0];
  assign rif.ramp_en = delay_ramp_enable_reg;
  assign rif.fast    = delay_ramp_rate_reg;

  tc_ramp u_ramp (
    .clk  (clk),
    .rstn (rstn),
    .rif  (rif)
  );

  // Delay controls to the clock path; the three are independent.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      delay_invert <= 1'b0;
      delay_coarse <= `TC_RST_COARSE;
      delay_fine   <= `TC_RST_FINE;
    end else begin
      delay_invert <= clock_invert_delay_reg; // see [R10]
      delay_coarse <= rif.cur;                // see [R11]
      delay_fine   <= fine_delay_step_reg;    // see [R12]
    end
  end

  // ----------------------------------------------------------------
  // Sample mode
  // ----------------------------------------------------------------
  // Dual mode takes rising samples only; single adds falling ones.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) mode_reg <= TC_MODE_DUAL;
    else if (wr_mode)
      mode_reg <= tc_mode_e'(reg_wdata[`TC_BIT_SINGLE]); // see [R5]
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) single_channel <= 1'b0;
    else single_channel <= (mode_reg == TC_MODE_SINGLE);
  end

  // ----------------------------------------------------------------
  // Frame settings
  // ----------------------------------------------------------------
  // Divider length is (demux + 1) times the frame length.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      demux_factor_setting_reg <= `TC_RST_DEMUX;
      frame_length_setting_reg <= `TC_RST_FRAME;
    end else begin
      if (wr_demux) demux_factor_setting_reg <= reg_wdata[1:0];
      if (wr_frame) frame_length_setting_reg <= reg_wdata[7:0];
    end
  end

  assign frame_period = 11'((demux_factor_setting_reg + 3'h1)
                            * frame_length_setting_reg); // see [R8]

  // ----------------------------------------------------------------
  // SYSREF capture
  // ----------------------------------------------------------------
  // Every capture happens on a rising clk edge, so alignment is fixed.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sysref_reg      <= 1'b0;
      sysref_prev_reg <= 1'b0;
    end else begin
      sysref_reg      <= sysref_in; // see [R9]
      sysref_prev_reg <= sysref_reg;
    end
  end

  assign sysref_edge = sysref_reg && !sysref_prev_reg;

  // Sticky capture flag; a new edge wins over a clear.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) sysref_seen_reg <= 1'b0;
    else if (sysref_edge) sysref_seen_reg <= 1'b1;
    else if (wr_status && reg_wdata[`TC_BIT_SYSREF_SEEN])
      sysref_seen_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Divider and strobe generator
  // ----------------------------------------------------------------
  assign frame_last     = (frame_cnt_reg + 11'h001) >= frame_period;
  assign frame_cnt_next = frame_last ? 11'h000
                                     : frame_cnt_reg + 11'h001;

  // SYSREF forces the divider back to phase zero.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) frame_cnt_reg <= 11'h000;
    else if (sysref_edge) frame_cnt_reg <= 11'h000; // see [R7]
    else frame_cnt_reg <= frame_cnt_next;
  end

  // Strobe marks the first word of each frame on the lanes.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) lane_strobe <= 1'b0;
    else lane_strobe <= sysref_edge || frame_last; // see [R7]
  end

  // Lane clock is clk halved, realigned by SYSREF.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) lane_clock <= 1'b0;
    else if (sysref_edge) lane_clock <= 1'b0; // see [R7]
    else lane_clock <= !lane_clock;           // see [R6]
  end

  // ----------------------------------------------------------------
  // Mark sampling
  // ----------------------------------------------------------------
  // Lane b takes the falling-instant trigger only in single mode.
  always_comb begin
    mark_a_next = trigger_mark_input[0];
    mark_b_next = (mode_reg == TC_MODE_SINGLE) ? trigger_mark_input[1]
                                               : trigger_mark_input[0];
    if (sysref_as_mark_select_reg) begin
      mark_a_next = sysref_in; // see [R4]
      mark_b_next = sysref_in;
    end
  end

  // Mark and words are caught in the same cycle as the samples.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mark_a_reg <= 1'b0;
      mark_b_reg <= 1'b0;
      conv_a_reg <= 12'h000;
      conv_b_reg <= 12'h000;
    end else begin
      mark_a_reg <= mark_a_next; // see [R3]
      mark_b_reg <= mark_b_next; // see [R5]
      conv_a_reg <= conv_a;
      conv_b_reg <= conv_b;
    end
  end

  // ----------------------------------------------------------------
  // Output lanes
  // ----------------------------------------------------------------
  tc_mark_pipe #(.LAT(PIPE_LAT)) u_lane_a (
    .clk     (clk),
    .rstn    (rstn),
    .conv    (conv_a_reg),
    .mark    (mark_a_reg),
    .ins_en  (mark_insert_enable_reg),
    .out_reg (lane_a_data)
  );

  tc_mark_pipe #(.LAT(PIPE_LAT)) u_lane_b (
    .clk     (clk),
    .rstn    (rstn),
    .conv    (conv_b_reg),
    .mark    (mark_b_reg),
    .ins_en  (mark_insert_enable_reg),
    .out_reg (lane_b_data)
  );

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  // Unmapped addresses and reserved bits read zero.
  always_comb begin
    rdata_next = 16'h0000;
    unique case (reg_addr)
      `TC_ADDR_CLK_CTRL_ONE:
        rdata_next[`TC_BIT_SYSREF_MARK] = sysref_as_mark_select_reg;
      `TC_ADDR_MARK_CTRL:
        rdata_next[`TC_BIT_MARK_EN] = mark_insert_enable_reg;
      `TC_ADDR_DELAY_CTRL: begin
        rdata_next[`TC_BIT_INV]       = clock_invert_delay_reg;
        rdata_next[`TC_BIT_RAMP_FAST] = delay_ramp_rate_reg;
        rdata_next[`TC_BIT_RAMP_EN]   = delay_ramp_enable_reg;
      end
      `TC_ADDR_COARSE: rdata_next[7:0] = coarse_delay_step_reg;
      `TC_ADDR_FINE:   rdata_next[7:0] = fine_delay_step_reg;
      `TC_ADDR_MODE:   rdata_next[`TC_BIT_SINGLE] = mode_reg;
      `TC_ADDR_DEMUX:  rdata_next[1:0] = demux_factor_setting_reg;
      `TC_ADDR_FRAME:  rdata_next[7:0] = frame_length_setting_reg;
      `TC_ADDR_STATUS: begin
        rdata_next[7:0]                = rif.cur;
        rdata_next[`TC_BIT_BUSY]       = rif.busy;
        rdata_next[`TC_BIT_SYSREF_SEEN] = sysref_seen_reg;
      end
      default: rdata_next = 16'h0000;
    endcase
  end

  // Read data stands in the cycle after the read strobe only.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) reg_rdata <= 16'h0000;
    else reg_rdata <= reg_rd ? rdata_next : 16'h0000;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_mark_source;
    @(posedge clk) disable iff (!rstn)
    sysref_as_mark_select_reg |=> mark_a_reg == $past(sysref_in);
  endproperty
  a_mark_source: assert property (p_mark_source) // see [R4]
    else $error("mark not taken from sysref");

  property p_mode_mark;
    @(posedge clk) disable iff (!rstn)
    !sysref_as_mark_select_reg && mode_reg == TC_MODE_SINGLE
      |=> mark_b_reg == $past(trigger_mark_input[1]);
  endproperty
  a_mode_mark: assert property (p_mode_mark) // see [R5]
    else $error("single mode falling mark not used");

  property p_sysref_reset;
    @(posedge clk) disable iff (!rstn)
    sysref_edge |=> frame_cnt_reg == 11'h000 && lane_strobe
                    && !lane_clock;
  endproperty
  a_sysref_reset: assert property (p_sysref_reset) // see [R7]
    else $error("sysref did not reset divider");

  property p_coarse_out;
    @(posedge clk) disable iff (!rstn)
    wr_coarse && !delay_ramp_enable_reg
      |=> ##1 delay_coarse == $past(reg_wdata[7:0], 2);
  endproperty
  a_coarse_out: assert property (p_coarse_out) // see [R16]
    else $error("direct coarse write not on output");
endmodule

// >>> pkg/tc_defs.svh
// Constants of the sample clock timing control block.
// Assumes inclusion by bare name from design or test files.
`ifndef TC_DEFS_SVH
`define TC_DEFS_SVH

// ----------------------------------------------------------------
// Register indices on the plain register port
// ----------------------------------------------------------------
`define TC_ADDR_CLK_CTRL_ONE 4'h0
`define TC_ADDR_MARK_CTRL    4'h1
`define TC_ADDR_DELAY_CTRL   4'h2
`define TC_ADDR_COARSE       4'h3
`define TC_ADDR_FINE         4'h4
`define TC_ADDR_MODE         4'h5
`define TC_ADDR_DEMUX        4'h6
`define TC_ADDR_FRAME        4'h7
`define TC_ADDR_STATUS       4'h8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TC_BIT_SYSREF_MARK   0
`define TC_BIT_MARK_EN       0
`define TC_BIT_INV           0
`define TC_BIT_RAMP_FAST     1
`define TC_BIT_RAMP_EN       2
`define TC_BIT_SINGLE        0
`define TC_BIT_BUSY          8
`define TC_BIT_SYSREF_SEEN   9

// ----------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------
`define TC_RST_COARSE        8'h00
`define TC_RST_FINE          8'h00
`define TC_RST_DEMUX         2'h0
`define TC_RST_FRAME         8'h01
`define TC_RAMP_SLOW_CYC     9'h100
`define TC_RAMP_FAST_CYC     9'h040

`endif

// >>> pkg/tc_pkg.sv
// Types of the sample clock timing control block.
// Assumes the constants header sits beside it.
package tc_pkg;
  typedef logic [7:0]  tc_delay_t;
  typedef logic [11:0] tc_sample_t;
  typedef enum logic [0:0] {
    TC_MODE_DUAL   = 1'b0,
    TC_MODE_SINGLE = 1'b1
  } tc_mode_e;
endpackage

// >>> pkg/tc_ramp_if.sv
// Link between the register side and the coarse delay ramp engine.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface tc_ramp_if;
  import tc_pkg::*;
  logic      wr;
  tc_delay_t target;
  logic      ramp_en;
  logic      fast;
  tc_delay_t cur;
  logic      busy;
  modport ctl (output wr, target, ramp_en, fast, input cur, busy);
  modport eng (input wr, target, ramp_en, fast, output cur, busy);
endinterface

// >>> test/tc_src_model.sv
// Far-side model: SYSREF source and trigger mark generator.
// Assumes it shares the device clock with the block under test.
`timescale 1ns/1ps
module tc_src_model (
  input  wire logic  clk,
  output logic       sysref_in,
  output logic [1:0] trigger_mark_input
);
  // Idle state: SYSREF low and no trigger marks.
  initial begin
    sysref_in = 1'b0;
    trigger_mark_input = 2'b00;
  end

  // Levels change just after an edge, so capture is deterministic.
  task automatic set_sysref(input logic v);
    @(posedge clk);
    sysref_in <= v;
  endtask

  // Trigger marks change away from the sampling edge as well.
  task automatic set_trig(input logic [1:0] v);
    @(posedge clk);
    trigger_mark_input <= v;
  endtask
endmodule

// >>> test/tc_timing_ctrl_tb_top.sv
// Self-checking bench of the sample clock timing control block.
// Assumes the source model drives SYSREF and the trigger marks.
`timescale 1ns/1ps
`include "tc_defs.svh"
module tc_timing_ctrl_tb_top import tc_pkg::*;;
  localparam int DLY = 3;
  logic        clk = 1'b0;
  logic        rstn;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [15:0] d;
  logic        reg_wr;
  logic        reg_rd;
  tc_sample_t  conv_a;
  tc_sample_t  conv_b;
  tc_sample_t  lane_a;
  tc_sample_t  lane_b;
  logic [1:0]  trig;
  logic        sysref;
  logic        lclk;
  logic        lstb;
  logic        inv;
  logic        single;
  tc_delay_t   coarse;
  tc_delay_t   fine;
  int          num_errors = 0;
  int          check_count = 0;

  // Free-running device clock.
  always #4 clk = ~clk;

  tc_timing_ctrl #(.PIPE_LAT(1)) i_dut (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .conv_a(conv_a), .conv_b(conv_b), .trigger_mark_input(trig),
    .sysref_in(sysref), .lane_a_data(lane_a), .lane_b_data(lane_b),
    .lane_clock(lclk), .lane_strobe(lstb), .delay_invert(inv),
    .delay_coarse(coarse), .delay_fine(fine), .single_channel(single));

  tc_src_model i_src (.clk(clk), .sysref_in(sysref),
    .trigger_mark_input(trig));

  // Compares one value and counts the outcome.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // Times one coarse step and checks it lands in its window.
  task automatic t_step(input tc_delay_t v, input int lo);
    int n;
    n = 0;
    while (coarse !== v && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({15'h0000, n >= lo && n <= lo + 4}, 16'h0001);
  endtask

  task automatic t_regs();
    rd(`TC_ADDR_FRAME);
    check(d, 16'h0001);
    rd(4'hF);
    check(d, 16'h0000);
  endtask

  task automatic t_mark();
    wr(`TC_ADDR_MARK_CTRL, 16'h0001);
    conv_a <= 12'hABC;
    conv_b <= 12'h456;
    i_src.set_trig(2'b01);
    settle(DLY + 3);
    check({4'h0, lane_a}, 16'h0ABD);
    check({4'h0, lane_b}, 16'h0457);
    i_src.set_trig(2'b10);
    settle(DLY + 3);
    check({4'h0, lane_a}, 16'h0ABC);
    check({4'h0, lane_b}, 16'h0456);
    wr(`TC_ADDR_MODE, 16'h0001);
    settle(DLY + 3);
    check({15'h0000, single}, 16'h0001);
    check({4'h0, lane_b}, 16'h0457);
    wr(`TC_ADDR_MARK_CTRL, 16'h0000);
    i_src.set_trig(2'b01);
    settle(DLY + 3);
    check({4'h0, lane_a}, 16'h0ABC);
    wr(`TC_ADDR_CLK_CTRL_ONE, 16'h0001);
    wr(`TC_ADDR_MARK_CTRL, 16'h0001);
    i_src.set_trig(2'b00);
    i_src.set_sysref(1'b1);
    settle(DLY + 3);
    check({4'h0, lane_a}, 16'h0ABD);
    i_src.set_sysref(1'b0);
    // Clear the capture flag so later status reads start from zero.
    wr(`TC_ADDR_STATUS, 16'h0200);
  endtask

  task automatic t_delay();
    wr(`TC_ADDR_DELAY_CTRL, 16'h0001);
    wr(`TC_ADDR_FINE, 16'h00FF);
    wr(`TC_ADDR_COARSE, 16'h0005);
    settle(2);
    check({15'h0000, inv}, 16'h0001);
    check({8'h00, fine}, 16'h00FF);
    check({8'h00, coarse}, 16'h0005);
    check({4'h0, lane_a}, 16'h0ABC);
  endtask

  task automatic t_ramp();
    wr(`TC_ADDR_DELAY_CTRL, 16'h0007);
    wr(`TC_ADDR_COARSE, 16'h0007);
    t_step(8'h06, 63);
    t_step(8'h07, 63);
    wr(`TC_ADDR_DELAY_CTRL, 16'h0004);
    wr(`TC_ADDR_COARSE, 16'h0006);
    t_step(8'h06, 255);
    settle(3);
    rd(`TC_ADDR_STATUS);
    check(d, 16'h0006);
  endtask

  // SYSREF must realign the frame strobe: next frame end 8 cycles on.
  task automatic t_sysref();
    int n;
    wr(`TC_ADDR_DEMUX, 16'h0001);
    wr(`TC_ADDR_FRAME, 16'h0004);
    i_src.set_sysref(1'b1);
    n = 0;
    settle(6);
    while (lstb !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check({15'h0000, n == 4}, 16'h0001);
    check({14'h0000, lclk, lstb}, 16'h0001);
    @(negedge clk);
    check({14'h0000, lclk, lstb}, 16'h0002);
    i_src.set_sysref(1'b0);
    rd(`TC_ADDR_STATUS);
    check(d, 16'h0206);
    wr(`TC_ADDR_STATUS, 16'h0200);
    rd(`TC_ADDR_STATUS);
    check(d, 16'h0006);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog cuts a hang short.
  initial begin
    #200000;
    num_errors++;
    summarize();
  end

  // Main sequence; every input idles quietly until reset lets go.
  initial begin
    rstn      <= 1'b0;
    reg_addr  <= 4'h0;
    reg_wdata <= 16'h0000;
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    conv_a    <= 12'h000;
    conv_b    <= 12'h000;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_mark();
    t_delay();
    t_ramp();
    t_sysref();
    summarize();
  end
endmodule
